/* File: hdl/tmb_buffers.v */
`include "tmb_defs.vh"
`default_nettype none
module tmb_buffers (
    input  wire                     mclk,
    input  wire                     rst_n,
    // Tape read side
    input  wire                     tin_valid,
    output wire                     tin_ready,
    input  wire [`TMB_WORD_W-1:0]   tin_data,
    input  wire [`TMB_UNIT_W-1:0]   tin_unit,
    input  wire                     tin_sec,
    input  wire                     tin_joint,
    // Transfer-in order
    input  wire                     xin_start,
    output wire                     xin_ready,
    input  wire                     xin_sec,
    input  wire                     xin_joint,
    input  wire [`TMB_ADDR_W-1:0]   xin_addr,
    input  wire [`TMB_ADDR_W-1:0]   xin_count,
    // Transfer-out order
    input  wire                     xout_start,
    output wire                     xout_ready,
    input  wire [`TMB_ADDR_W-1:0]   xout_addr,
    input  wire [`TMB_ADDR_W-1:0]   xout_count,
    // Write order
    input  wire                     wr_start,
    output wire                     wr_ready,
    // Tape record side
    output wire                     tout_valid,
    input  wire                     tout_ready,
    output wire [`TMB_WORD_W-1:0]   tout_data,
    output wire                     tout_key,
    // Core memory side port
    input  wire                     cpu_we,
    input  wire [`TMB_ADDR_W-1:0]   cpu_addr,
    input  wire [`TMB_WORD_W-1:0]   cpu_wdata,
    output reg  [`TMB_WORD_W-1:0]   cpu_rdata,
    output wire                     cpu_special,
    output wire                     cpu_reserved,
    // Status
    output reg                      sentinel_q,
    output reg  [`TMB_UNIT_W-1:0]   last_unit_q,
    output reg                      blk_tick_q,
    output wire                     busy
);
    localparam [1:0] S_IDLE = 2'b00;
    localparam [1:0] S_RUN  = 2'b01;

    // ==========================================================
    // Helper functions
    // ==========================================================
    function is_sentinel;
        input [`TMB_WORD_W-1:0] w;
        begin
            is_sentinel = (w[`TMB_WORD_W-1:`TMB_WORD_W-2] == 2'b00);
        end
    endfunction

    // ==========================================================
    // Storage
    // ==========================================================
    // whole-word core
    reg [`TMB_WORD_W-1:0] core_mem [0:`TMB_MEM_WORDS-1];
    reg [`TMB_WORD_W-1:0] in_mem  [0:1][0:61];
    // accumulate (A) and record (B) sections
    reg [`TMB_WORD_W-1:0] oa_mem  [0:61];
    reg [`TMB_WORD_W-1:0] ob_mem  [0:61];

    // ==========================================================
    // Input sync (tape pins cross into mclk)
    // ==========================================================
    reg tv_s1_q;
    reg tv_s2_q;
    reg [`TMB_WORD_W-1:0] td_s1_q;
    reg [`TMB_WORD_W-1:0] td_s2_q;
    reg [`TMB_UNIT_W-1:0] tu_s1_q;
    reg [`TMB_UNIT_W-1:0] tu_s2_q;
    reg [1:0]             tsj_s1_q;
    reg [1:0]             tsj_s2_q;
    reg tv_prev_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tv_s1_q   <= 1'b0;
            tv_s2_q   <= 1'b0;
            td_s1_q   <= `TMB_FILLER;
            td_s2_q   <= `TMB_FILLER;
            tu_s1_q   <= {`TMB_UNIT_W{1'b0}};
            tu_s2_q   <= {`TMB_UNIT_W{1'b0}};
            tsj_s1_q  <= 2'b00;
            tsj_s2_q  <= 2'b00;
            tv_prev_q <= 1'b0;
        end else begin
            tv_s1_q   <= tin_valid;
            tv_s2_q   <= tv_s1_q;
            td_s1_q   <= tin_data;
            td_s2_q   <= td_s1_q;
            tu_s1_q   <= tin_unit;
            tu_s2_q   <= tu_s1_q;
            tsj_s1_q  <= {tin_joint, tin_sec};
            tsj_s2_q  <= tsj_s1_q;
            tv_prev_q <= tv_s2_q;
        end
    end
    // Level handshake: a new word is a rising valid
    wire tin_word = tv_s2_q && !tv_prev_q;
    // Section and joint select pass the same two stages as the word
    wire sync_sec   = tsj_s2_q[0];
    wire sync_joint = tsj_s2_q[1];

    // ==========================================================
    // Input fill from tape
    // ==========================================================
    reg [6:0] fill_cnt_q;
    reg       fill_sec_q;
    reg       fill_joint_q;
    reg       fill_act_q;
    reg [1:0] drn_busy;
    wire fill_blk = sync_joint ? (|drn_busy) : drn_busy[sync_sec];
    assign tin_ready = !fill_blk;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fill_cnt_q   <= 7'h00;
            fill_sec_q   <= 1'b0;
            fill_joint_q <= 1'b0;
            fill_act_q   <= 1'b0;
            last_unit_q  <= {`TMB_UNIT_W{1'b0}};
        end else if (tin_word) begin
            if (tu_s2_q < `TMB_NUM_UNITS)
                last_unit_q <= tu_s2_q;
            if (!fill_act_q && !fill_blk) begin
                fill_act_q   <= 1'b1;
                fill_sec_q   <= sync_joint ? 1'b0 : sync_sec;
                fill_joint_q <= sync_joint;
                fill_cnt_q   <= 7'h01;
                in_mem[sync_joint ? 1'b0 : sync_sec][0] <= td_s2_q;
            end else if (fill_act_q) begin
                if (fill_cnt_q < 7'h3e)
                    in_mem[fill_sec_q][fill_cnt_q[5:0]] <= td_s2_q;
                else
                    in_mem[1][fill_cnt_q[5:0] - 6'h3e] <= td_s2_q;
                fill_cnt_q <= fill_cnt_q + 7'h01;
                if (fill_cnt_q == (fill_joint_q ? 7'h7b : 7'h3d))
                    fill_act_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Memory transfers (one word per cycle)
    // ==========================================================
    reg [1:0]             xst_q;
    reg                   xdir_q;
    reg                   xsec_q;
    reg                   xjoint_q;
    reg [6:0]             xidx_q;
    reg [`TMB_ADDR_W-1:0] xaddr_q;
    reg [`TMB_ADDR_W-1:0] xleft_q;
    reg [6:0]             oa_cnt_q;
    reg [5:0]             oa_head_q;
    always @* begin
        drn_busy = 2'b00;
        if (xst_q == S_RUN && !xdir_q) begin
            drn_busy[xsec_q] = 1'b1;
            if (xjoint_q)
                drn_busy = 2'b11;
        end
    end
    // fill blocks a drain of its own section, or any drain when the fill or the drain is joint
    wire in_blk = xin_joint ? fill_act_q : (fill_act_q &&
                  (fill_joint_q || fill_sec_q == xin_sec));
    assign xin_ready  = (xst_q == S_IDLE) && !in_blk;
    assign xout_ready = (xst_q == S_IDLE);
    assign busy       = (xst_q != S_IDLE) || fill_act_q;

    // non-destructive read, fillers past the data
    wire [`TMB_WORD_W-1:0] in_word =
        (xidx_q >= (xjoint_q ? 7'h7c : 7'h3e)) ? `TMB_FILLER :
        (xidx_q < 7'h3e) ? in_mem[xsec_q][xidx_q[5:0]] :
        in_mem[1][xidx_q[5:0] - 6'h3e];
    wire [`TMB_WORD_W-1:0] xword = xdir_q ? core_mem[xaddr_q] : in_word;
    wire [5:0] oa_wptr = (oa_cnt_q >= 7'h3e) ?
        oa_head_q : oa_cnt_q[5:0];

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            xst_q      <= S_IDLE;
            xdir_q     <= 1'b0;
            xsec_q     <= 1'b0;
            xjoint_q   <= 1'b0;
            xidx_q     <= 7'h00;
            xaddr_q    <= {`TMB_ADDR_W{1'b0}};
            xleft_q    <= {`TMB_ADDR_W{1'b0}};
            sentinel_q <= 1'b0;
            oa_cnt_q   <= 7'h00;
            oa_head_q  <= 6'h00;
        end else begin
            case (xst_q)
            S_IDLE: begin
                if (xin_start && xin_ready && xin_count != 11'd0) begin
                    xst_q    <= S_RUN;
                    xdir_q   <= 1'b0;
                    xsec_q   <= xin_joint ? 1'b0 : xin_sec;
                    xjoint_q <= xin_joint;
                    xidx_q   <= 7'h00;
                    xaddr_q  <= xin_addr;
                    xleft_q  <= xin_count;
                end else if (xout_start && xout_count != 11'd0) begin
                    xst_q   <= S_RUN;
                    xdir_q  <= 1'b1;
                    xaddr_q <= xout_addr;
                    xleft_q <= xout_count;
                end
                if (wr_start && wr_ready) begin
                    oa_cnt_q  <= 7'h00;
                    oa_head_q <= 6'h00;
                end
                if (cpu_we && cpu_addr < `TMB_MEM_WORDS)
                    core_mem[cpu_addr] <= cpu_wdata;
            end
            S_RUN: begin
                sentinel_q <= is_sentinel(xword);
                if (!xdir_q) begin
                    if (xaddr_q < `TMB_MEM_WORDS)
                        core_mem[xaddr_q] <= xword;
                    xidx_q <= xidx_q + 7'h01;
                end else begin
                    oa_mem[oa_wptr] <= xword;
                    if (oa_cnt_q < 7'h3e)
                        oa_cnt_q <= oa_cnt_q + 7'h01;
                    else
                        oa_head_q <= (oa_head_q == 6'h3d) ?
                            6'h00 : oa_head_q + 6'h01;
                end
                xaddr_q <= xaddr_q + 11'd1;
                xleft_q <= xleft_q - 11'd1;
                if (xleft_q == 11'd1)
                    xst_q <= S_IDLE;
            end
            default: xst_q <= S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Record section B toward tape
    // ==========================================================
    reg       rec_act_q;
    reg [5:0] rec_idx_q;
    reg [6:0] rec_n_q;
    reg [1:0] sk_n_q;
    integer   k;
    wire sk_in_rdy = (sk_n_q != 2'd2);
    // write waits for recording and loading
    assign wr_ready = !rec_act_q && !tout_valid && (xst_q == S_IDLE);
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rec_act_q <= 1'b0;
            rec_idx_q <= 6'h00;
            rec_n_q   <= 7'h00;
        end else if (wr_start && wr_ready) begin
            // move A into B, oldest first
            for (k = 0; k < 62; k = k + 1)
                ob_mem[k] <= oa_mem[(k + oa_head_q) % 62];
            rec_n_q   <= oa_cnt_q;
            rec_act_q <= 1'b1;
            rec_idx_q <= 6'h00;
        end else if (rec_act_q && sk_in_rdy) begin
            rec_idx_q <= rec_idx_q + 6'h01;
            if (rec_idx_q == 6'h3d)
                rec_act_q <= 1'b0;
        end
    end

    // ==========================================================
    // Two-entry skid buffer to tape
    // ==========================================================
    reg [`TMB_WORD_W:0] sk_q [0:1];
    wire [`TMB_WORD_W-1:0] rec_word = ({1'b0, rec_idx_q} < rec_n_q) ?
        ob_mem[rec_idx_q] : `TMB_FILLER;
    wire sk_push = rec_act_q && sk_in_rdy;
    wire sk_pop  = tout_valid && tout_ready;
    assign tout_valid = (sk_n_q != 2'd0);
    assign tout_data  = sk_q[0][`TMB_WORD_W-1:0];
    // first two words in key channel
    assign tout_key   = sk_q[0][`TMB_WORD_W];
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sk_n_q <= 2'd0;
            sk_q[0] <= {1'b0, `TMB_FILLER};
            sk_q[1] <= {1'b0, `TMB_FILLER};
        end else begin
            if (sk_pop)
                sk_q[0] <= sk_q[1];
            if (sk_push) begin
                if (sk_n_q == 2'd0 || (sk_n_q == 2'd1 && sk_pop))
                    sk_q[0] <= {rec_idx_q < 6'h02, rec_word};
                else
                    sk_q[sk_pop ? 0 : 1] <= {rec_idx_q < 6'h02, rec_word};
            end
            sk_n_q <= sk_n_q + {1'b0, sk_push} - {1'b0, sk_pop};
        end
    end

    // ==========================================================
    // Processor port and block-rate tick
    // ==========================================================
    // special words / reserved range
    assign cpu_special  = (cpu_addr >= `TMB_SPC_LO) &&
                          (cpu_addr <= `TMB_SPC_HI);
    assign cpu_reserved = (cpu_addr >= `TMB_CTL_LO) &&
                          (cpu_addr <= `TMB_CTL_HI);
    // one tick per tape block time
    reg [16:0] tick_cnt_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_rdata  <= `TMB_FILLER;
            tick_cnt_q <= 17'h0_0000;
            blk_tick_q <= 1'b0;
        end else begin
            if (cpu_addr < `TMB_MEM_WORDS)
                cpu_rdata <= core_mem[cpu_addr];
            blk_tick_q <= (tick_cnt_q == `TMB_BLK_CYC - 1);
            tick_cnt_q <= (tick_cnt_q == `TMB_BLK_CYC - 1) ?
                17'h0_0000 : tick_cnt_q + 17'h0_0001;
        end
    end
endmodule
`default_nettype wire

/* File: shared/tmb_defs.vh */
`ifndef TMB_DEFS_VH
`define TMB_DEFS_VH
`define TMB_WORD_W      52
`define TMB_BLOCK_WORDS 7'h3e
`define TMB_IDX_W       6
`define TMB_MEM_WORDS   2000
`define TMB_ADDR_W      11
`define TMB_CTL_LO      11'h7_bf
`define TMB_CTL_HI      11'h7_c5
`define TMB_SPC_LO      11'h7_c6
`define TMB_SPC_HI      11'h7_cf
`define TMB_NUM_UNITS   10
`define TMB_UNIT_W      4
`define TMB_FILLER      52'h0_0000_0000_0000
`define TMB_BLK_PER_S   80
`define TMB_CLK_HZ      10000000
`define TMB_BLK_CYC     (`TMB_CLK_HZ / `TMB_BLK_PER_S)
`endif

/* File: verification/tmb_buffers_asserts.sv */
`include "tmb_defs.vh"
`default_nettype none
module tmb_buffers_asserts (
    input wire logic                   mclk,
    input wire logic                   rst_n,
    input wire logic                   xin_start,
    input wire logic                   xin_ready,
    input wire logic [`TMB_ADDR_W-1:0] xin_count,
    input wire logic                   wr_start,
    input wire logic                   wr_ready,
    input wire logic                   tout_valid,
    input wire logic                   tout_ready,
    input wire logic [`TMB_WORD_W-1:0] tout_data,
    input wire logic                   tout_key,
    input wire logic [`TMB_ADDR_W-1:0] cpu_addr,
    input wire logic                   cpu_special,
    input wire logic                   cpu_reserved,
    input wire logic [`TMB_UNIT_W-1:0] last_unit_q,
    input wire logic                   busy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ========================================
    // Words handed over since the write order
    logic [6:0] rec_cnt_q;
    logic [6:0] rec_cnt_d;
    always_comb begin
        rec_cnt_d = rec_cnt_q;
        if (wr_start && wr_ready)
            rec_cnt_d = 7'h00;
        else if (tout_valid && tout_ready)
            rec_cnt_d = rec_cnt_q + 7'h01;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            rec_cnt_q <= 7'h00;
        else
            rec_cnt_q <= rec_cnt_d;
    end
    // ========================================
    // Properties
    sequence s_wr_taken;
        wr_start && wr_ready;
    endsequence
    sequence s_first_key;
        !tout_valid ##1 (tout_valid && tout_key);
    endsequence
    a_special_decode: assert property (cpu_special ==
        (cpu_addr >= `TMB_SPC_LO && cpu_addr <= `TMB_SPC_HI))
        else $error("special decode wrong");
    a_reserved_decode: assert property (cpu_reserved ==
        (cpu_addr >= `TMB_CTL_LO && cpu_addr <= `TMB_CTL_HI))
        else $error("reserved decode wrong");
    a_unit_range: assert property (last_unit_q < `TMB_NUM_UNITS)
        else $error("unit out of range");
    a_tout_hold: assert property (tout_valid && !tout_ready |=>
        tout_valid && $stable(tout_data) && $stable(tout_key))
        else $error("record word not held");
    a_wr_walk: assert property (s_wr_taken |=> s_first_key)
        else $error("record start late");
    a_key_first: assert property (tout_valid |->
        tout_key == (rec_cnt_q < 7'd2))
        else $error("key flag wrong");
    a_block_len: assert property (tout_valid |-> rec_cnt_q < 7'd62)
        else $error("block too long");
    a_rec_no_wr: assert property (tout_valid |-> !wr_ready)
        else $error("write ready while recording");
    a_xin_busy: assert property (xin_start && xin_ready &&
        xin_count != 11'h000 |=> busy)
        else $error("transfer not busy");
endmodule
bind tmb_buffers tmb_buffers_asserts tmb_buffers_asserts_inst (
    .mclk(mclk), .rst_n(rst_n), .xin_start(xin_start),
    .xin_ready(xin_ready), .xin_count(xin_count), .wr_start(wr_start),
    .wr_ready(wr_ready), .tout_valid(tout_valid), .tout_ready(tout_ready),
    .tout_data(tout_data), .tout_key(tout_key), .cpu_addr(cpu_addr),
    .cpu_special(cpu_special), .cpu_reserved(cpu_reserved),
    .last_unit_q(last_unit_q), .busy(busy));
`default_nettype wire

/* File: verification/tmb_buffers_bench.sv */
`include "tmb_defs.vh"
`default_nettype none
module tmb_buffers_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rst_n, slow, tin_valid, tin_ready, tin_sec, tin_joint;
    logic xin_start, xin_ready, xin_sec, xin_joint, xout_start, xout_ready;
    logic wr_start, wr_ready, tout_valid, tout_ready, tout_key, cpu_we;
    logic cpu_special, cpu_reserved, sentinel_q, blk_tick_q, busy;
    logic [`TMB_WORD_W-1:0] tin_data, tout_data, cpu_wdata, cpu_rdata, w;
    logic [`TMB_UNIT_W-1:0] tin_unit, last_unit_q, unit;
    logic [`TMB_ADDR_W-1:0] xin_addr, xin_count, xout_addr, xout_count;
    logic [`TMB_ADDR_W-1:0] cpu_addr;
    logic [`TMB_WORD_W-1:0] exp_q[$];
    logic [31:0] seed;
    int n_fail, compares, i;
    int tbl[5] = '{1982, 1983, 1989, 1990, 1999};

    tmb_buffers tmb_buffers_inst (.mclk(mclk), .rst_n(rst_n),
        .tin_valid(tin_valid), .tin_ready(tin_ready), .tin_data(tin_data),
        .tin_unit(tin_unit), .tin_sec(tin_sec), .tin_joint(tin_joint),
        .xin_start(xin_start), .xin_ready(xin_ready), .xin_sec(xin_sec),
        .xin_joint(xin_joint), .xin_addr(xin_addr), .xin_count(xin_count),
        .xout_start(xout_start), .xout_ready(xout_ready),
        .xout_addr(xout_addr), .xout_count(xout_count),
        .wr_start(wr_start), .wr_ready(wr_ready), .tout_valid(tout_valid),
        .tout_ready(tout_ready), .tout_data(tout_data), .tout_key(tout_key),
        .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata), .cpu_special(cpu_special),
        .cpu_reserved(cpu_reserved), .sentinel_q(sentinel_q),
        .last_unit_q(last_unit_q), .blk_tick_q(blk_tick_q), .busy(busy));
    tmb_tape_model tmb_tape_model_inst (.mclk(mclk), .slow(slow),
        .tin_valid(tin_valid), .tin_ready(tin_ready), .tin_data(tin_data),
        .tin_unit(tin_unit), .tin_sec(tin_sec), .tin_joint(tin_joint),
        .tout_valid(tout_valid), .tout_ready(tout_ready),
        .tout_data(tout_data), .tout_key(tout_key));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // ========================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic rnd_word();
        seed = lfsr(seed);
        // Top bits often 00 so sentinels occur
        w = {seed[31:30] & {2{seed[3]}}, seed, seed[17:0]};
    endtask
    task automatic check(input logic [`TMB_WORD_W-1:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic complete_run();
        if (n_fail == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic mem_wr(input int a, input logic [`TMB_WORD_W-1:0] d);
        @(negedge mclk);
        cpu_we = 1'b1;
        cpu_addr = a[10:0];
        cpu_wdata = d;
        @(negedge mclk);
        cpu_we = 1'b0;
    endtask
    task automatic mem_rd(input int a);
        @(negedge mclk);
        cpu_addr = a[10:0];
        @(negedge mclk);
    endtask
    task automatic wait_idle();
        for (i = 0; i < 3000 && busy !== 1'b0; i++)
            @(negedge mclk);
        if (busy !== 1'b0)
            n_fail++;
    endtask
    // Start held until ready is seen before the taking edge
    task automatic order(input int k);
        @(negedge mclk);
        xin_start = (k == 0);
        xout_start = (k == 1);
        wr_start = (k == 2);
        for (i = 0; i < 3000 && !((k == 0 && xin_ready) ||
             (k == 1 && xout_ready) || (k == 2 && wr_ready)); i++)
            @(negedge mclk);
        @(negedge mclk);
        {xin_start, xout_start, wr_start} = 3'b000;
    endtask
    task automatic fill(input logic s, j, input int n);
        exp_q.delete();
        seed = lfsr(seed);
        unit = seed[7:0] % 10;
        for (int k = 0; k < n; k++) begin
            rnd_word();
            exp_q.push_back(w);
            tmb_tape_model_inst.send_word(w, unit, s, j);
        end
        check(last_unit_q, unit);
    endtask
    task automatic drain(input logic s, j, input int a, c);
        {xin_sec, xin_joint, xin_addr, xin_count} = {s, j, a[10:0], c[10:0]};
        mem_wr(a + c, `TMB_FILLER);
        order(0);
        check(tin_ready, 1'b0);
        mem_wr(a + c, 52'h0_0000_0000_0001);
        wait_idle();
        for (int k = 0; k < c; k++) begin
            mem_rd(a + k);
            check(cpu_rdata, k < exp_q.size() ? exp_q[k] : `TMB_FILLER);
        end
        mem_rd(a + c);
        check(cpu_rdata, 52'h0_0000_0000_0000);
    endtask
    task automatic rec_check(input int skip, n);
        for (i = 0; i < 5000 && tmb_tape_model_inst.rec_q.size() < 62; i++)
            @(negedge mclk);
        for (int k = 0; k < 62; k++) begin
            check(tmb_tape_model_inst.rec_q[k],
                  k < n ? exp_q[skip + k] : `TMB_FILLER);
            check(tmb_tape_model_inst.key_q[k], k < 2);
        end
        check(tmb_tape_model_inst.rec_q.size(), 62);
        tmb_tape_model_inst.rec_q.delete();
        tmb_tape_model_inst.key_q.delete();
    endtask
    // ========================================
    // Main sequence
    initial begin
        {rst_n, slow, xin_start, xin_sec, xin_joint, xout_start} = '0;
        {wr_start, cpu_we, xin_addr, xin_count, xout_addr} = '0;
        {xout_count, cpu_addr, cpu_wdata} = '0;
        seed = 32'he251_b53b;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        check({tout_valid, sentinel_q, blk_tick_q}, 3'b000);
        for (int k = 0; k < 5; k++) begin
            mem_rd(tbl[k]);
            check({cpu_special, cpu_reserved},
                  {tbl[k] >= 1990, tbl[k] >= 1983 && tbl[k] <= 1989});
        end
        mem_wr(1990, 52'hf_1234_5678_9abc);
        mem_rd(1990);
        check(cpu_rdata, 52'hf_1234_5678_9abc);
        fill(1'b1, 1'b0, 62);
        drain(1'b1, 1'b0, 100, 64);
        check(sentinel_q, 1'b1);
        fill(1'b0, 1'b1, 124);
        drain(1'b0, 1'b1, 300, 126);
        exp_q.delete();
        for (int k = 0; k < 64; k++) begin
            rnd_word();
            w[51] = (k == 63);
            exp_q.push_back(w);
            mem_wr(1000 + k, w);
        end
        slow = 1'b1;
        {xout_addr, xout_count} = {11'h3_e8, 11'h0_40};
        order(1);
        wait_idle();
        check(sentinel_q, 1'b0);
        order(2);
        rec_check(2, 62);
        xout_count = 11'h0_03;
        order(1);
        wait_idle();
        order(2);
        rec_check(0, 3);
        complete_run();
    end
    initial begin
        #2_000_000;
        n_fail++;
        complete_run();
    end
endmodule
`default_nettype wire

/* File: verification/tmb_tape_model.sv */
`include "tmb_defs.vh"
`default_nettype none
module tmb_tape_model (
    input  wire logic                   mclk,
    input  wire logic                   slow,
    output var  logic                   tin_valid,
    input  wire logic                   tin_ready,
    output var  logic [`TMB_WORD_W-1:0] tin_data,
    output var  logic [`TMB_UNIT_W-1:0] tin_unit,
    output var  logic                   tin_sec,
    output var  logic                   tin_joint,
    input  wire logic                   tout_valid,
    output var  logic                   tout_ready,
    input  wire logic [`TMB_WORD_W-1:0] tout_data,
    input  wire logic                   tout_key
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [`TMB_WORD_W-1:0] rec_q[$];
    logic                   key_q[$];
    logic [1:0]             stall_q = 2'h0;
    initial begin
        tin_valid = 1'b0;
        tin_data = '0;
        tin_unit = '0;
        tin_sec = 1'b0;
        tin_joint = 1'b0;
    end
    // ========================================
    // Tape read: word held past the 2FF sync
    task automatic send_word(input logic [`TMB_WORD_W-1:0] w,
                             input logic [3:0] u, input logic s, j);
        int i;
        for (i = 0; i < 3000 && tin_ready !== 1'b1; i++)
            @(negedge mclk);
        tin_data = w;
        tin_unit = u;
        tin_sec = s;
        tin_joint = j;
        tin_valid = 1'b1;
        repeat (4) @(negedge mclk);
        tin_valid = 1'b0;
        // Released line shows the inverse, not a stale word
        tin_data = ~w;
        repeat (3) @(negedge mclk);
    endtask
    // ========================================
    // Recorder: stalls one cycle in four when slow
    always @(negedge mclk) begin
        stall_q <= stall_q + 2'h1;
        tout_ready <= !(slow && stall_q == 2'h0);
    end
    always @(posedge mclk) begin
        if (tout_valid && tout_ready) begin
            rec_q.push_back(tout_data);
            key_q.push_back(tout_key);
        end
    end
endmodule
`default_nettype wire
